// *** include/cio_pkg.sv ***
// What this block does
// - Eight input data lines carry one eight-bit character, each line its own driver.
// - A short trigger pulse yields a 6 us pulse on the stretched strobe output.
// - Device drives an inverted primary strobe; wiring returns it as complement.
// - Read-discrete op samples hw bits 1-13, 14-18 and 25-30 into accumulator.
// - Hw bit one is the accumulator LSB, program bit thirty-one.
// - Eight output data lines carry eight-level or five-level code.
// - Alphanumeric flag high only in alphanumeric-5, alphanumeric-4 and decimal modes.
// - Octal flag high only in octal, alphanumeric-6 out and in modes.
// - Output-valid level high while valid data sits on the output lines.
// - Output-valid pulse of 1 to 2 us marks new output data.
// - Codes 3702, 3704, 3706 switch on discrete outputs one, two, three.
// - Remote error reset clears the error flag, resets and halts.
// - Output blanking forces all eight output data lines to zero.
// - Complement strobe false enters sampling; its return moves to processing.
// - Parity select grounded gives even output parity, open gives odd.
package cio_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int STRETCH_NS = 6000;
	localparam int STRETCH_CYC = (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int VPULSE_MIN_NS = 1000;
	localparam int VPULSE_MAX_NS = 2000;
	localparam int VPULSE_CYC = (VPULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] OUT_ADDR = 8'h04;
	localparam logic [7:0] OP_ADDR = 8'h08;
	localparam logic [7:0] ACC_ADDR = 8'h0c;
	localparam logic [7:0] CHAR_ADDR = 8'h10;
	localparam logic [7:0] STAT_ADDR = 8'h14;

	// Control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_PAR_BIT = 4;
	localparam int CTRL_PEER_BIT = 5;
	localparam int CTRL_OUT_CLR_BIT = 6;
	localparam int CTRL_RUN_BIT = 7;
	localparam int CTRL_ERR_SET_BIT = 8;

	// Status fields
	localparam int ST_HALT_BIT = 0;
	localparam int ST_ERR_BIT = 1;
	localparam int ST_CHAR_BIT = 2;
	localparam int ST_RECV_BIT = 3;
	localparam int ST_REFUSED_BIT = 4;
	localparam int ST_FB_BIT = 5;
	localparam int ST_PEER_OK_BIT = 6;
	localparam int ST_VALID_BIT = 7;
	localparam int ST_SECTOR_LSB = 16;
	localparam int ST_CHAN_LSB = 24;

	localparam logic HALT_RST = 1'b0;
	localparam logic [7:0] RECV_CHANNEL = 8'h00;
	localparam logic [7:0] RECV_SECTOR = 8'h07;

	// Operation codes, octal 3700/3702/3704/3706; read-discrete code arbitrary
	localparam logic [11:0] OP_DISC_CLR = 12'h7c0;
	localparam logic [11:0] OP_DISC_ONE = 12'h7c2;
	localparam logic [11:0] OP_DISC_TWO = 12'h7c4;
	localparam logic [11:0] OP_DISC_THREE = 12'h7c6;
	localparam logic [11:0] OP_READ_DISC = 12'h7d0;

	typedef enum logic [2:0] {
		MODE_NONE = 3'h0,
		MODE_AN5 = 3'h1,
		MODE_AN4 = 3'h2,
		MODE_DEC = 3'h3,
		MODE_OCT = 3'h4,
		MODE_AN6_OUT = 3'h5,
		MODE_AN6_IN = 3'h6
	} cio_mode_type;

	typedef enum logic [3:0] {
		IN_IDLE = 4'h1,
		IN_SAMPLE = 4'h2,
		IN_PROC = 4'h4,
		IN_WAIT = 4'h8
	} cio_in_state_type;

	typedef struct packed {
		logic [7:0] in_data;
		logic primary_input_strobe;
		logic complement_input_strobe;
		logic input_feedback;
		logic stretcher_trigger_in;
		logic [4:0] disc_lo;
		logic [5:0] disc_hi;
		logic peer_transfer_enable;
		logic remote_error_reset;
		logic remote_receive_start;
		logic output_blanking;
		logic output_parity_select;
	} cio_pin_in_type;

	typedef struct packed {
		logic [7:0] out_data;
		logic alphanumeric_mode_flag;
		logic octal_mode_flag;
		logic output_valid_level;
		logic output_valid_pulse;
		logic discrete_out_one;
		logic discrete_out_two;
		logic discrete_out_three;
		logic inverted_strobe_out;
		logic stretched_strobe_out;
	} cio_pin_out_type;

endpackage

// *** verif/cio_peer_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module cio_peer_model
(
	input wire logic sys_clk, // Clock
	input wire logic inverted_strobe_out, // From device
	input wire logic stretched_strobe_out, // From device
	output logic [7:0] in_data, // Character lines
	output logic primary_input_strobe, // Strobe out
	output logic complement_input_strobe, // Returned strobe
	output logic input_feedback, // Feedback line
	output logic stretcher_trigger_in // Short strobe
);
	logic strobe = 1'b0;
	logic use_st = 1'b0;

	initial
	begin
		in_data = 8'h00;
		stretcher_trigger_in = 1'b0;
	end
	assign input_feedback = 1'b0;
	assign complement_input_strobe = inverted_strobe_out;
	assign primary_input_strobe = use_st ? stretched_strobe_out : strobe;

	task automatic send(input logic [7:0] c, input logic st);
		int n;
		@(posedge sys_clk);
		in_data <= c;
		use_st <= st;
		if (st)
		begin
			stretcher_trigger_in <= 1'b1;
			repeat (200) @(posedge sys_clk);
			stretcher_trigger_in <= 1'b0;
			for (n = 0; n < 1000 && stretched_strobe_out !== 1'b0; n++)
				@(posedge sys_clk);
		end
		else
		begin
			strobe <= 1'b1;
			repeat (620) @(posedge sys_clk);
			strobe <= 1'b0;
		end
		repeat (30) @(posedge sys_clk);
		// Released lines must not keep showing the last character
		in_data <= ~c;
	endtask
endmodule

`default_nettype wire

// *** verif/cio_port_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module cio_port_sva
(
	input wire logic sys_clk, // Clock
	input wire logic rst, // Reset
	input wire logic [7:0] paddr, // Address
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [31:0] pwdata, // Write data
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [12:0] input_matrix, // Matrix bits
	input wire cio_pkg::cio_pin_in_type pin_in, // Pins in
	input wire cio_pkg::cio_pin_out_type pin_out // Pins out
);
	logic [11:0] st_cnt;
	logic [11:0] vp_cnt;

	////////////////////////////////////////////////////////////////////////
	// Run lengths of the two timed pulses, judged when they fall
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			st_cnt <= 12'h000;
			vp_cnt <= 12'h000;
		end
		else
		begin
			st_cnt <= pin_out.stretched_strobe_out ? st_cnt + 12'h001 : 12'h000;
			vp_cnt <= pin_out.output_valid_pulse ? vp_cnt + 12'h001 : 12'h000;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	a_ready_timing: assert property ((psel && !penable) ##1 (psel && penable)
		|=> pready) else $error("ready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready too long");
	a_err_addr: assert property (pready && paddr > 8'h14 |-> pslverr)
		else $error("unmapped not refused");
	a_blank_zero: assert property (pin_in.output_blanking [*8] |->
		pin_out.out_data == 8'h00) else $error("blanking ignored");
	a_one_discrete: assert property ($onehot0({pin_out.discrete_out_one,
		pin_out.discrete_out_two, pin_out.discrete_out_three}))
		else $error("two discretes on");
	a_stretch_len: assert property ($fell(pin_out.stretched_strobe_out)
		|-> st_cnt == cio_pkg::STRETCH_CYC) else $error("stretch length");
	a_vpulse_len: assert property ($fell(pin_out.output_valid_pulse)
		|-> vp_cnt == cio_pkg::VPULSE_CYC) else $error("valid pulse length");
	a_inv_strobe: assert property ($stable(pin_in.primary_input_strobe) [*8]
		|-> pin_out.inverted_strobe_out == !pin_in.primary_input_strobe)
		else $error("inverted strobe wrong");
	a_mode_flags: assert property (!(pin_out.alphanumeric_mode_flag &&
		pin_out.octal_mode_flag)) else $error("both mode flags");
	a_valid_level: assert property (pin_out.output_valid_pulse |->
		pin_out.output_valid_level) else $error("pulse without level");

	c_refused: cover property (pready && pslverr);
	c_stretch: cover property ($fell(pin_out.stretched_strobe_out));
	c_third: cover property (pin_out.discrete_out_three);
endmodule

`default_nettype wire

// *** verif/cio_port_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module cio_port_test;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [12:0] input_matrix = 13'h0;
	logic [4:0] disc_lo = 5'h0;
	logic [5:0] disc_hi = 6'h0;
	logic peer_en = 1'b0;
	logic err_rst = 1'b0;
	logic recv = 1'b0;
	logic blank = 1'b0;
	logic par = 1'b0;
	logic [7:0] m_data;
	logic m_prim, m_comp, m_fb, m_trig;
	cio_pkg::cio_pin_in_type pin_in;
	cio_pkg::cio_pin_out_type pin_out;
	logic [64:0] note_q [$];
	logic [64:0] note;
	logic [7:0] c;
	int error_cnt = 0;
	int num_checks = 0;
	int i;

	assign pin_in = {m_data, m_prim, m_comp, m_fb, m_trig, disc_lo, disc_hi,
		peer_en, err_rst, recv, blank, par};
	always #5 sys_clk = ~sys_clk;

	cio_port dut (.sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .input_matrix(input_matrix),
		.pin_in(pin_in), .pin_out(pin_out));
	cio_peer_model peer (.sys_clk(sys_clk),
		.inverted_strobe_out(pin_out.inverted_strobe_out),
		.stretched_strobe_out(pin_out.stretched_strobe_out), .in_data(m_data),
		.primary_input_strobe(m_prim), .complement_input_strobe(m_comp),
		.input_feedback(m_fb), .stretcher_trigger_in(m_trig));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		// Ready is read before this edge's updates, as the slave sees it
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			chk(32'h0, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] msk, input logic err = 1'b0);
		note_q.push_back({err, msk, exp});
		apb(a, 1'b0, 32'h0);
	endtask

	task automatic end_of_test();
		$display("Checks %0d, errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Read answers are taken at the edge that samples ready high
	always @(posedge sys_clk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite && note_q.size() > 0)
		begin
			note = note_q.pop_front();
			chk(prdata & note[63:32], note[31:0]);
			chk({31'h0, pslverr}, {31'h0, note[64]});
		end
	end

	initial
	begin
		#400000;
		error_cnt++;
		end_of_test();
	end

	initial
	begin
		i = $urandom(32'h1d5fec8f);
		wt(20);
		rst <= 1'b0;
		wt(10);
		rd(cio_pkg::STAT_ADDR, 32'h00070000, 32'hffff0003);
		rd(8'h18, 32'h0, 32'hffffffff, 1'b1);
		for (i = 0; i < 3; i++)
		begin
			wr(cio_pkg::OP_ADDR, {20'h0, cio_pkg::OP_DISC_ONE + 12'(2 * i)});
			wt(3);
			@(negedge sys_clk);
			chk({29'h0, pin_out.discrete_out_three, pin_out.discrete_out_two,
				pin_out.discrete_out_one}, 32'(1 << i));
			rd(cio_pkg::OP_ADDR, 32'(1 << i), 32'h7);
		end
		wr(cio_pkg::OP_ADDR, {20'h0, cio_pkg::OP_DISC_CLR});
		rd(cio_pkg::OP_ADDR, 32'h0, 32'h7);
		for (i = 0; i < 7; i++)
		begin
			wr(cio_pkg::CTRL_ADDR, 32'(i));
			wt(3);
			@(negedge sys_clk);
			chk({30'h0, pin_out.alphanumeric_mode_flag, pin_out.octal_mode_flag},
				{30'h0, 1'(i > 0 && i < 4), 1'(i > 3)});
		end
		c = 8'($urandom);
		wr(cio_pkg::CTRL_ADDR, 32'h0);
		wr(cio_pkg::OUT_ADDR, {24'h0, c});
		wt(2);
		@(negedge sys_clk);
		chk({22'h0, pin_out.out_data, pin_out.output_valid_level,
			pin_out.output_valid_pulse}, {22'h0, c, 2'b11});
		wt(1);
		blank <= 1'b1;
		wt(8);
		@(negedge sys_clk);
		chk({24'h0, pin_out.out_data}, 32'h0);
		for (i = 0; i < 2; i++)
		begin
			wt(1);
			blank <= 1'b0;
			par <= i[0];
			// Spacing lets the last valid pulse end before the next write
			wt(100);
			wr(cio_pkg::CTRL_ADDR, 32'h10);
			wr(cio_pkg::OUT_ADDR, {24'h0, c});
			wt(2);
			@(negedge sys_clk);
			chk({24'h0, pin_out.out_data},
				{24'h0, (^c[6:0]) ^ i[0], c[6:0]});
		end
		wt(100);
		wr(cio_pkg::CTRL_ADDR, 32'h40);
		wt(2);
		@(negedge sys_clk);
		chk({31'h0, pin_out.output_valid_level}, 32'h0);
		wr(cio_pkg::CTRL_ADDR, 32'h20);
		wr(cio_pkg::OUT_ADDR, {24'h0, ~c});
		rd(cio_pkg::STAT_ADDR, 32'h10, 32'h10);
		wr(cio_pkg::STAT_ADDR, 32'h18);
		peer_en <= 1'b1;
		wt(8);
		wr(cio_pkg::OUT_ADDR, {24'h0, ~c});
		rd(cio_pkg::STAT_ADDR, 32'hc0, 32'hd0);
		rd(cio_pkg::OUT_ADDR, {24'h0, ~c}, 32'hff);
		wr(cio_pkg::CTRL_ADDR, 32'h0);
		disc_lo <= 5'($urandom);
		disc_hi <= 6'($urandom);
		input_matrix <= 13'($urandom);
		wt(8);
		wr(cio_pkg::OP_ADDR, {20'h0, cio_pkg::OP_READ_DISC});
		rd(cio_pkg::ACC_ADDR, {2'b0, disc_hi, 6'b0, disc_lo, input_matrix},
			32'hffffffff);
		for (i = 0; i < 2; i++)
		begin
			c = 8'($urandom);
			peer.send(c, i[0]);
			wt(10);
			rd(cio_pkg::STAT_ADDR, 32'h4, 32'h4);
			rd(cio_pkg::CHAR_ADDR, {24'h0, c}, 32'hff);
			rd(cio_pkg::STAT_ADDR, 32'h0, 32'h4);
		end
		wr(cio_pkg::OP_ADDR, {20'h0, cio_pkg::OP_DISC_TWO});
		wr(cio_pkg::CTRL_ADDR, 32'h100);
		rd(cio_pkg::STAT_ADDR, 32'h2, 32'h2);
		err_rst <= 1'b1;
		wt(10);
		err_rst <= 1'b0;
		wt(5);
		rd(cio_pkg::STAT_ADDR, 32'h1, 32'h3);
		rd(cio_pkg::OP_ADDR, 32'h0, 32'h7);
		wr(cio_pkg::OP_ADDR, {20'h0, cio_pkg::OP_DISC_ONE});
		rd(cio_pkg::STAT_ADDR, 32'h10, 32'h10);
		recv <= 1'b1;
		wt(10);
		recv <= 1'b0;
		wt(5);
		rd(cio_pkg::STAT_ADDR, 32'h8, 32'h9);
		wt(5);
		end_of_test();
	end
endmodule

bind cio_port cio_port_sva sva_i (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.input_matrix(input_matrix), .pin_in(pin_in), .pin_out(pin_out));

`default_nettype wire

// *** verilog/cio_port.sv ***
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module cio_port
(
	input wire logic sys_clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic [7:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [12:0] input_matrix, // Hw bits 1-13, internal
	input wire cio_pkg::cio_pin_in_type pin_in, // Connector inputs
	output cio_pkg::cio_pin_out_type pin_out // Connector outputs
);

	cio_pkg::cio_pin_in_type pin_s;

	cio_sync #(.W($bits(cio_pkg::cio_pin_in_type))) u_sync
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.d(pin_in),
		.q(pin_s)
	);

	////////////////////////////////////////////////////////////////////////
	// APB slave: answer in the second access cycle

	logic apb_acc;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] rd_val;
	logic rd_ok;
	logic [31:0] prdata_next;
	logic pready_next;
	logic pslverr_next;

	assign apb_acc = psel & penable;
	assign wr_fire = apb_acc & pready & pwrite;
	assign rd_fire = apb_acc & pready & ~pwrite;

	// Core state
	cio_pkg::cio_mode_type mode_reg, mode_next;
	logic par_en_reg, par_en_next;
	logic peer_reg, peer_next;
	logic halt_reg, halt_next;
	logic err_reg, err_next;
	logic recv_reg, recv_next;
	logic refused_reg, refused_next;
	logic [31:0] acc_reg, acc_next;
	logic [7:0] out_raw_reg, out_raw_next;
	logic valid_reg, valid_next;
	logic [7:0] vcnt_reg, vcnt_next;
	logic [2:0] disc_reg, disc_next;
	logic [9:0] scnt_reg, scnt_next;
	logic trig_prev_reg;
	logic err_pin_prev_reg;
	logic rcv_pin_prev_reg;

	// Input character path
	cio_pkg::cio_in_state_type in_state_reg, in_state_next;
	logic [7:0] cap_reg, cap_next;
	logic [7:0] char_reg, char_next;
	logic char_flag_reg, char_flag_next;

	logic peer_ok;
	logic err_pin_rise;
	logic rcv_pin_rise;
	logic out_blocked;

	assign peer_ok = pin_s.peer_transfer_enable;
	assign err_pin_rise = pin_s.remote_error_reset & ~err_pin_prev_reg;
	assign rcv_pin_rise = pin_s.remote_receive_start & ~rcv_pin_prev_reg;
	assign out_blocked = halt_reg | (peer_reg & ~peer_ok);

	always_comb
	begin
		rd_val = 32'h0;
		rd_ok = 1'b1;
		case (paddr)
			cio_pkg::CTRL_ADDR:
			begin
				rd_val[cio_pkg::CTRL_MODE_LSB +: 3] = mode_reg;
				rd_val[cio_pkg::CTRL_PAR_BIT] = par_en_reg;
				rd_val[cio_pkg::CTRL_PEER_BIT] = peer_reg;
			end
			cio_pkg::OUT_ADDR: rd_val[7:0] = out_raw_reg;
			cio_pkg::OP_ADDR: rd_val[2:0] = disc_reg;
			cio_pkg::ACC_ADDR: rd_val = acc_reg;
			cio_pkg::CHAR_ADDR: rd_val[7:0] = char_reg;
			cio_pkg::STAT_ADDR:
			begin
				rd_val[cio_pkg::ST_HALT_BIT] = halt_reg;
				rd_val[cio_pkg::ST_ERR_BIT] = err_reg;
				rd_val[cio_pkg::ST_CHAR_BIT] = char_flag_reg;
				rd_val[cio_pkg::ST_RECV_BIT] = recv_reg;
				rd_val[cio_pkg::ST_REFUSED_BIT] = refused_reg;
				rd_val[cio_pkg::ST_FB_BIT] = pin_s.input_feedback;
				rd_val[cio_pkg::ST_PEER_OK_BIT] = peer_ok;
				rd_val[cio_pkg::ST_VALID_BIT] = valid_reg;
				rd_val[cio_pkg::ST_SECTOR_LSB +: 8] = cio_pkg::RECV_SECTOR;
				rd_val[cio_pkg::ST_CHAN_LSB +: 8] = cio_pkg::RECV_CHANNEL;
			end
			default: rd_ok = 1'b0;
		endcase
		pready_next = apb_acc & ~pready;
		prdata_next = prdata;
		pslverr_next = 1'b0;
		if (apb_acc & ~pready)
		begin
			prdata_next = pwrite ? 32'h0 : rd_val;
			pslverr_next = ~rd_ok;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input strobe sequencer

	always_comb
	begin
		in_state_next = in_state_reg;
		cap_next = cap_reg;
		char_next = char_reg;
		char_flag_next = char_flag_reg;
		// Reading the character clears its flag; a new one wins
		if (rd_fire && paddr == cio_pkg::CHAR_ADDR)
			char_flag_next = 1'b0;
		case (in_state_reg)
			cio_pkg::IN_IDLE:
			begin
				if (!pin_s.complement_input_strobe)
					in_state_next = cio_pkg::IN_SAMPLE;
			end
			cio_pkg::IN_SAMPLE:
			begin
				cap_next = pin_s.in_data;
				if (pin_s.complement_input_strobe)
					in_state_next = cio_pkg::IN_PROC;
			end
			cio_pkg::IN_PROC:
			begin
				char_next = cap_reg;
				char_flag_next = 1'b1;
				in_state_next = cio_pkg::IN_WAIT;
			end
			cio_pkg::IN_WAIT:
			begin
				// Held strobe must end before the next character
				if (pin_s.complement_input_strobe &&
					!pin_s.primary_input_strobe)
					in_state_next = cio_pkg::IN_IDLE;
			end
			default: in_state_next = cio_pkg::IN_WAIT;
		endcase
		if (err_pin_rise)
		begin
			char_flag_next = 1'b0;
			in_state_next = cio_pkg::IN_WAIT;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			// Starting in wait avoids a false character from reset levels
			in_state_reg <= cio_pkg::IN_WAIT;
			cap_reg <= 8'h00;
			char_reg <= 8'h00;
			char_flag_reg <= 1'b0;
		end
		else
		begin
			in_state_reg <= in_state_next;
			cap_reg <= cap_next;
			char_reg <= char_next;
			char_flag_reg <= char_flag_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control, output and discrete logic

	logic [7:0] out_drive;
	logic par_bit;
	cio_pkg::cio_pin_out_type pin_out_next;

	always_comb
	begin
		mode_next = mode_reg;
		par_en_next = par_en_reg;
		peer_next = peer_reg;
		halt_next = halt_reg;
		err_next = err_reg;
		recv_next = recv_reg;
		refused_next = refused_reg;
		acc_next = acc_reg;
		out_raw_next = out_raw_reg;
		valid_next = valid_reg;
		vcnt_next = (vcnt_reg != 8'h00) ? vcnt_reg - 8'h01 : 8'h00;
		disc_next = disc_reg;
		scnt_next = (scnt_reg != 10'h000) ? scnt_reg - 10'h001 : 10'h000;
		if (pin_s.stretcher_trigger_in && !trig_prev_reg &&
			scnt_reg == 10'h000)
			scnt_next = 10'(cio_pkg::STRETCH_CYC);
		if (wr_fire)
		begin
			case (paddr)
				cio_pkg::CTRL_ADDR:
				begin
					mode_next = cio_pkg::cio_mode_type'(
						pwdata[cio_pkg::CTRL_MODE_LSB +: 3]);
					par_en_next = pwdata[cio_pkg::CTRL_PAR_BIT];
					peer_next = pwdata[cio_pkg::CTRL_PEER_BIT];
					if (pwdata[cio_pkg::CTRL_OUT_CLR_BIT])
						valid_next = 1'b0;
					if (pwdata[cio_pkg::CTRL_RUN_BIT])
						halt_next = 1'b0;
					if (pwdata[cio_pkg::CTRL_ERR_SET_BIT])
						err_next = 1'b1;
				end
				cio_pkg::OUT_ADDR:
				begin
					if (out_blocked)
						refused_next = 1'b1;
					else
					begin
						out_raw_next = pwdata[7:0];
						valid_next = 1'b1;
						vcnt_next = 8'(cio_pkg::VPULSE_CYC);
					end
				end
				cio_pkg::OP_ADDR:
				begin
					if (halt_reg)
						refused_next = 1'b1;
					else
					begin
						case (pwdata[11:0])
							cio_pkg::OP_DISC_CLR: disc_next = 3'h0;
							cio_pkg::OP_DISC_ONE: disc_next = 3'h1;
							cio_pkg::OP_DISC_TWO: disc_next = 3'h2;
							cio_pkg::OP_DISC_THREE: disc_next = 3'h4;
							cio_pkg::OP_READ_DISC: acc_next = {2'h0,
								pin_s.disc_hi, 6'h00, pin_s.disc_lo,
								input_matrix};
							default: refused_next = 1'b1;
						endcase
					end
				end
				cio_pkg::STAT_ADDR:
				begin
					if (pwdata[cio_pkg::ST_RECV_BIT])
						recv_next = 1'b0;
					if (pwdata[cio_pkg::ST_REFUSED_BIT])
						refused_next = 1'b0;
				end
				default: ;
			endcase
		end
		// Hardware events after software so a pin event beats a register write
		if (wr_fire && paddr == cio_pkg::OUT_ADDR && out_blocked)
			refused_next = 1'b1;
		if (rcv_pin_rise && halt_reg)
		begin
			halt_next = 1'b0;
			recv_next = 1'b1;
		end
		if (err_pin_rise)
		begin
			err_next = 1'b0;
			halt_next = 1'b1;
			recv_next = 1'b0;
			mode_next = cio_pkg::MODE_NONE;
			valid_next = 1'b0;
			vcnt_next = 8'h00;
			disc_next = 3'h0;
		end
	end

	assign par_bit = (^out_raw_reg[6:0]) ^ pin_s.output_parity_select;

	always_comb
	begin
		out_drive = par_en_reg ? {par_bit, out_raw_reg[6:0]} : out_raw_reg;
		if (pin_s.output_blanking)
			out_drive = 8'h00;
		pin_out_next.out_data = out_drive;
		pin_out_next.alphanumeric_mode_flag = 1'b0;
		pin_out_next.octal_mode_flag = 1'b0;
		case (mode_reg)
			cio_pkg::MODE_AN5, cio_pkg::MODE_AN4, cio_pkg::MODE_DEC:
				pin_out_next.alphanumeric_mode_flag = 1'b1;
			cio_pkg::MODE_OCT, cio_pkg::MODE_AN6_OUT, cio_pkg::MODE_AN6_IN:
				pin_out_next.octal_mode_flag = 1'b1;
			default: ;
		endcase
		pin_out_next.output_valid_level = valid_reg;
		pin_out_next.output_valid_pulse = (vcnt_reg != 8'h00);
		pin_out_next.discrete_out_one = disc_reg[0];
		pin_out_next.discrete_out_two = disc_reg[1];
		pin_out_next.discrete_out_three = disc_reg[2];
		pin_out_next.inverted_strobe_out = ~pin_s.primary_input_strobe;
		pin_out_next.stretched_strobe_out = (scnt_reg != 10'h000);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			mode_reg <= cio_pkg::MODE_NONE;
			par_en_reg <= 1'b0;
			peer_reg <= 1'b0;
			halt_reg <= cio_pkg::HALT_RST;
			err_reg <= 1'b0;
			recv_reg <= 1'b0;
			refused_reg <= 1'b0;
			acc_reg <= 32'h0;
			out_raw_reg <= 8'h00;
			valid_reg <= 1'b0;
			vcnt_reg <= 8'h00;
			disc_reg <= 3'h0;
			scnt_reg <= 10'h000;
			trig_prev_reg <= 1'b0;
			err_pin_prev_reg <= 1'b0;
			rcv_pin_prev_reg <= 1'b0;
			pin_out <= '0;
		end
		else
		begin
			mode_reg <= mode_next;
			par_en_reg <= par_en_next;
			peer_reg <= peer_next;
			halt_reg <= halt_next;
			err_reg <= err_next;
			recv_reg <= recv_next;
			refused_reg <= refused_next;
			acc_reg <= acc_next;
			out_raw_reg <= out_raw_next;
			valid_reg <= valid_next;
			vcnt_reg <= vcnt_next;
			disc_reg <= disc_next;
			scnt_reg <= scnt_next;
			trig_prev_reg <= pin_s.stretcher_trigger_in;
			err_pin_prev_reg <= pin_s.remote_error_reset;
			rcv_pin_prev_reg <= pin_s.remote_receive_start;
			pin_out <= pin_out_next;
		end
	end

endmodule
`default_nettype wire

// *** verilog/cio_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module cio_sync
#(
	parameter int W = 8
)
(
	input wire logic sys_clk, // System clock
	input wire logic rst, // Async reset, high
	input wire logic [W-1:0] d, // Raw pin levels
	output logic [W-1:0] q // Settled levels
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_next;

	// A bit moves only once the second and third stages agree
	always_comb
	begin
		q_next = (s2_reg & s3_reg) | (q & (s2_reg | s3_reg));
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q <= '0;
		end
		else
		begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q <= q_next;
		end
	end

endmodule
`default_nettype wire
